// file: src/rsif_status_irq.sv
`timescale 1ns/1ps

module rsif_status_irq
    import rsif_pkg::*;
(
    input  wire logic           i_clk,
    input  wire logic           i_nrst,
    input  wire rsif_events_t   i_events,
    input  wire rsif_levels_t   i_levels,
    input  wire rsif_port_cfg_t i_port_cfg,
    input  wire rsif_reg_req_t  i_reg,
    output logic [7:0]          o_reg_rdata,
    output logic                o_irq
);

    logic [7:0] status;
    logic       slip;
    logic [7:0] int_en;
    logic       slip_en;
    logic [7:0] next_status;
    logic       next_slip;
    logic       slip_event;
    logic [7:0] ev_vec;
    logic [7:0] lvl_vec;
    logic       rd_status;
    logic       rd_slip;

    rsif_slip_select u_slip_select (
        .i_cfg    (i_port_cfg),
        .i_slip_a (i_events.slip_a),
        .i_slip_b (i_events.slip_b),
        .o_slip   (slip_event)
    );

    assign rd_status = i_reg.rd & (i_reg.addr == RSIF_ERR_STATUS_ADDR);
    assign rd_slip   = i_reg.rd & (i_reg.addr == RSIF_SLIP_STATUS_ADDR);

    always_comb begin
        ev_vec                     = 8'h00;
        lvl_vec                    = 8'h00;
        ev_vec[RSIF_BIT_CHAN_STAT] = i_events.chan_stat_check_err;
        ev_vec[RSIF_BIT_PARITY]    = i_events.parity_err;
        ev_vec[RSIF_BIT_BIPHASE]   = i_events.biphase_err;
        ev_vec[RSIF_BIT_SUB_CHG]   = i_events.subcode_changed;
        ev_vec[RSIF_BIT_SUB_CRC]   = i_events.subcode_check_err;
        ev_vec[RSIF_BIT_BUF_COPY]  = i_events.buffer_copy_done;
        lvl_vec[RSIF_BIT_VALIDITY] = i_levels.data_invalid;
        lvl_vec[RSIF_BIT_UNLOCK]   = i_levels.decoder_unlocked | i_levels.pll_unlocked;
        // A new event in the clearing read's cycle survives the clear
        next_status = ((((rd_status ? 8'h00 : status) | ev_vec) & RSIF_STICKY_MASK) | lvl_vec);
        next_slip   = (rd_slip ? 1'b0 : slip) | slip_event;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            status <= RSIF_STATUS_RESET;
            slip   <= RSIF_SLIP_RESET;
        end else begin
            status <= next_status;
            slip   <= next_slip;
        end
    end

    // Enable registers; a read never touches them
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            int_en  <= RSIF_INT_EN_RESET;
            slip_en <= RSIF_SLIP_INT_EN_RESET;
        end else if (i_reg.wr) begin
            if (i_reg.addr == RSIF_INT_EN_ADDR) begin
                int_en <= i_reg.wdata;
            end
            if (i_reg.addr == RSIF_SLIP_INT_EN_ADDR) begin
                slip_en <= i_reg.wdata[RSIF_BIT_SLIP];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg.rd) begin
            unique case (i_reg.addr)
                RSIF_ERR_STATUS_ADDR:  o_reg_rdata <= status;
                RSIF_SLIP_STATUS_ADDR: o_reg_rdata <= {7'h00, slip};
                RSIF_INT_EN_ADDR:      o_reg_rdata <= int_en;
                RSIF_SLIP_INT_EN_ADDR: o_reg_rdata <= {7'h00, slip_en};
                default:               o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Registered so the pin never glitches as flags settle
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (|(status & int_en)) | (slip & slip_en);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence read_status_s;
        rd_status ##1 1'b1;
    endsequence

    sequence both_fed_b_slip_s;
        i_port_cfg.a_from_rx && i_port_cfg.b_from_rx && i_events.slip_b && !i_events.slip_a;
    endsequence

    enable_reset_zero_a: assert property ($rose(i_nrst) |-> int_en == 8'h00 && !slip_en)
        else $error("Enable bytes not zero after reset");

    irq_masked_off_a: assert property ((int_en == 8'h00 && !slip_en) [*2] |-> !o_irq)
        else $error("Interrupt raised with all enables clear");

    irq_enabled_flag_a: assert property ((status[RSIF_BIT_UNLOCK] && int_en[RSIF_BIT_UNLOCK]) |=> o_irq)
        else $error("Enabled unlock flag gave no interrupt");

    set_beats_clear_a: assert property ((rd_status && i_events.parity_err) |=> status[RSIF_BIT_PARITY])
        else $error("Parity event lost under read clear");

    sticky_hold_a: assert property ((i_events.chan_stat_check_err ##1 !rd_status) |=>
            status[RSIF_BIT_CHAN_STAT])
        else $error("Channel-status check flag did not hold");

    read_clears_a: assert property ((read_status_s ##0 !i_events.subcode_changed) and
            (rd_status && !i_events.subcode_changed) |=> !status[RSIF_BIT_SUB_CHG])
        else $error("Sub-code changed flag not cleared by read");

    unlock_level_a: assert property (1'b1 |=> status[RSIF_BIT_UNLOCK] ==
            ($past(i_levels.decoder_unlocked) || $past(i_levels.pll_unlocked)))
        else $error("Unlock flag does not follow lock state");

    validity_level_a: assert property (1'b1 |=> status[RSIF_BIT_VALIDITY] == $past(i_levels.data_invalid))
        else $error("Validity flag does not follow input");

    slip_gate_a: assert property ($rose(slip) |-> $past((i_port_cfg.a_from_rx && i_port_cfg.a_slave) ||
            (i_port_cfg.b_from_rx && i_port_cfg.b_slave)))
        else $error("Slip raised with no slave port fed");

    slip_port_a_a: assert property ((both_fed_b_slip_s and !slip) |=> !slip)
        else $error("Port B slip seen while both ports fed");

    slip_high_zero_a: assert property (rd_slip |=> o_reg_rdata[7:1] == 7'h00)
        else $error("Slip status upper bits not zero");

    read_keeps_en_a: assert property ((i_reg.rd && !i_reg.wr) |=> $stable(int_en) && $stable(slip_en))
        else $error("Read altered enable settings");

endmodule : rsif_status_irq

// file: src/rsif_pkg.sv
package rsif_pkg;

    // Register offsets on the internal control port
    localparam logic [7:0] RSIF_ERR_STATUS_ADDR  = 8'h14;
    localparam logic [7:0] RSIF_SLIP_STATUS_ADDR = 8'h15;
    localparam logic [7:0] RSIF_INT_EN_ADDR      = 8'h16;
    localparam logic [7:0] RSIF_SLIP_INT_EN_ADDR = 8'h17;

    // Reset values
    localparam logic [7:0] RSIF_INT_EN_RESET      = 8'h00;
    localparam logic       RSIF_SLIP_INT_EN_RESET = 1'b0;
    localparam logic [7:0] RSIF_STATUS_RESET      = 8'h00;
    localparam logic       RSIF_SLIP_RESET        = 1'b0;

    // Field positions of the error status byte and its enable byte, and of the slip status and slip enable bytes
    localparam int RSIF_BIT_CHAN_STAT = 7;
    localparam int RSIF_BIT_PARITY    = 6;
    localparam int RSIF_BIT_VALIDITY  = 5;
    localparam int RSIF_BIT_BIPHASE   = 4;
    localparam int RSIF_BIT_SUB_CHG   = 3;
    localparam int RSIF_BIT_UNLOCK    = 2;
    localparam int RSIF_BIT_SUB_CRC   = 1;
    localparam int RSIF_BIT_BUF_COPY  = 0;
    localparam int RSIF_BIT_SLIP      = 0;

    // Bits that latch until read; the rest follow their live condition
    localparam logic [7:0] RSIF_STICKY_MASK = 8'hdb;

    typedef struct packed {
        logic chan_stat_check_err;
        logic parity_err;
        logic biphase_err;
        logic subcode_changed;
        logic subcode_check_err;
        logic buffer_copy_done;
        logic slip_a;
        logic slip_b;
    } rsif_events_t;

    typedef struct packed {
        logic data_invalid;
        logic decoder_unlocked;
        logic pll_unlocked;
    } rsif_levels_t;

    typedef struct packed {
        logic a_from_rx;
        logic a_slave;
        logic b_from_rx;
        logic b_slave;
    } rsif_port_cfg_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsif_reg_req_t;

endpackage : rsif_pkg

// file: src/rsif_slip_select.sv
`timescale 1ns/1ps

module rsif_slip_select
    import rsif_pkg::*;
(
    input  wire rsif_port_cfg_t i_cfg,
    input  wire logic           i_slip_a,
    input  wire logic           i_slip_b,
    output logic                o_slip
);

    logic a_watch;
    logic b_watch;

    // Port A wins when both ports take the receiver output
    assign a_watch = i_cfg.a_from_rx & i_cfg.a_slave;
    assign b_watch = i_cfg.b_from_rx & i_cfg.b_slave & ~i_cfg.a_from_rx;
    assign o_slip  = (a_watch & i_slip_a) | (b_watch & i_slip_b);

endmodule : rsif_slip_select

// file: verification/rsif_host.sv
`timescale 1ns/1ps

module rsif_host
    import rsif_pkg::*;
(
    input  wire logic    i_clk,
    output rsif_reg_req_t o_reg
);
    initial o_reg = '0;

    // One register access; address and data go stale-inverted once released
    task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) #1;
        o_reg = '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge i_clk) #1;
        o_reg = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
endmodule : rsif_host

// file: verification/receiver_status_interrupt_flags_bench.sv
`timescale 1ns/1ps

module receiver_status_interrupt_flags_bench
    import rsif_pkg::*;
;
    logic           i_clk;
    logic           i_nrst;
    rsif_events_t   i_events;
    rsif_levels_t   i_levels;
    rsif_port_cfg_t i_port_cfg;
    rsif_reg_req_t  i_reg;
    logic [7:0]     o_reg_rdata;
    logic           o_irq;
    int             n_mismatch = 0;
    int             compares   = 0;
    int             cycles     = 0;
    logic [7:0]     pos [6]    = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h02, 8'h01};
    logic [3:0]     cfg [5]    = '{4'b1100, 4'b1000, 4'b0011, 4'b1111, 4'b1111};
    logic [7:0]     sev [5]    = '{8'h02, 8'h02, 8'h01, 8'h01, 8'h02};
    logic [7:0]     sx  [5]    = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01};

    rsif_status_irq dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_events(i_events), .i_levels(i_levels),
        .i_port_cfg(i_port_cfg), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .o_irq(o_irq));
    rsif_host host (.i_clk(i_clk), .o_reg(i_reg));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.xfer(1'b1, a, 8'h00);
        chk(o_reg_rdata, exp);
    endtask : rdc

    task automatic ev(input logic [7:0] v);
        @(posedge i_clk) #1;
        i_events = v;
        @(posedge i_clk) #1;
        i_events = '0;
    endtask : ev

    // Interrupt lags the flag by a cycle, so allow two edges
    task automatic irqc(input logic exp);
        repeat (2) @(posedge i_clk);
        #1;
        chk({7'h00, o_irq}, {7'h00, exp});
    endtask : irqc

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        i_events   = '0;
        i_levels   = '0;
        i_port_cfg = '0;
        i_nrst     = 1'b0;
        repeat (12) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        rdc(8'h16, 8'h00);
        rdc(8'h14, 8'h00);
        rdc(8'h15, 8'h00);
        rdc(8'h17, 8'h00);
        chk({7'h00, o_irq}, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            ev(8'h80 >> i);
            rdc(8'h14, pos[i]);
            rdc(8'h14, 8'h00);
        end
        i_levels = 3'b100;
        rdc(8'h14, 8'h20);
        i_levels = 3'b010;
        rdc(8'h14, 8'h04);
        i_levels = 3'b001;
        rdc(8'h14, 8'h04);
        $display("test flags done");
        host.xfer(1'b0, 8'h16, 8'h04);
        irqc(1'b1);
        host.xfer(1'b0, 8'h16, 8'hfb);
        irqc(1'b0);
        host.xfer(1'b0, 8'h14, 8'hff);
        rdc(8'h14, 8'h04);
        rdc(8'h16, 8'hfb);
        ev(8'h40);
        irqc(1'b1);
        i_levels = '0;
        rdc(8'h14, 8'h40);
        irqc(1'b0);
        rdc(8'h20, 8'h00);
        // Event and clearing read at one edge: the set must win
        fork
            host.xfer(1'b1, 8'h14, 8'h00);
            ev(8'h40);
        join
        chk(o_reg_rdata, 8'h00);
        rdc(8'h14, 8'h40);
        $display("test mask done");
        for (int i = 0; i < 5; i++) begin
            i_port_cfg = cfg[i];
            ev(sev[i]);
            irqc(1'b0);
            rdc(8'h15, sx[i]);
        end
        host.xfer(1'b0, 8'h17, 8'h01);
        rdc(8'h17, 8'h01);
        ev(8'h02);
        irqc(1'b1);
        rdc(8'h15, 8'h01);
        irqc(1'b0);
        $display("test slip done");
        conclude();
    end
endmodule : receiver_status_interrupt_flags_bench
